// file: hdl/gpmux_pkg.sv
package gpmux_pkg;

   // ----------------------------------------------------------------
   // geometry
   // ----------------------------------------------------------------
   localparam int GPMUX_PORTS = 5;
   localparam int GPMUX_PW = 8;
   localparam int GPMUX_P_L = 0;
   localparam int GPMUX_P_M = 1;
   localparam int GPMUX_P_N = 2;
   localparam int GPMUX_P_O = 3;
   localparam int GPMUX_P_P = 4;

   // ----------------------------------------------------------------
   // register indices (byte address is four times the index)
   // ----------------------------------------------------------------
   localparam logic [31:0] GPMUX_IDX_M_DATA = 32'hFFFFF0C0;
   localparam logic [31:0] GPMUX_IDX_L_DATA = 32'hFFFFF0C1;
   localparam logic [31:0] GPMUX_IDX_M_DIR = 32'hFFFFF0C4;
   localparam logic [31:0] GPMUX_IDX_L_DIR = 32'hFFFFF0C5;
   localparam logic [31:0] GPMUX_IDX_L_FUNC = 32'hFFFFF0C9;
   localparam logic [31:0] GPMUX_IDX_P_DATA = 32'hFFFFF0D1;
   localparam logic [31:0] GPMUX_IDX_O_DATA = 32'hFFFFF0D2;
   localparam logic [31:0] GPMUX_IDX_N_DATA = 32'hFFFFF0D3;
   localparam logic [31:0] GPMUX_IDX_P_DIR = 32'hFFFFF0D5;
   localparam logic [31:0] GPMUX_IDX_O_DIR = 32'hFFFFF0D6;
   localparam logic [31:0] GPMUX_IDX_N_DIR = 32'hFFFFF0D7;
   localparam logic [31:0] GPMUX_IDX_N_FUNC = 32'hFFFFF0DB;
   localparam logic [31:0] GPMUX_IDX_N_DRIVE = 32'hFFFFF0DF;
   localparam int GPMUX_IDX_LSB = 2;
   localparam int GPMUX_IDX_W = 8;

   // per-port tables, port k in byte k
   localparam logic [39:0] GPMUX_DATA_IDX = {GPMUX_IDX_P_DATA[7:0], GPMUX_IDX_O_DATA[7:0],
      GPMUX_IDX_N_DATA[7:0], GPMUX_IDX_M_DATA[7:0], GPMUX_IDX_L_DATA[7:0]};
   localparam logic [39:0] GPMUX_DIR_IDX = {GPMUX_IDX_P_DIR[7:0], GPMUX_IDX_O_DIR[7:0],
      GPMUX_IDX_N_DIR[7:0], GPMUX_IDX_M_DIR[7:0], GPMUX_IDX_L_DIR[7:0]};
   localparam logic [39:0] GPMUX_FUNC_IDX = {8'h00, 8'h00, GPMUX_IDX_N_FUNC[7:0], 8'h00,
      GPMUX_IDX_L_FUNC[7:0]};
   localparam logic [39:0] GPMUX_DRIVE_IDX = {8'h00, 8'h00, GPMUX_IDX_N_DRIVE[7:0], 8'h00,
      8'h00};
   localparam logic [39:0] GPMUX_FUNC_MASK = 40'h00_00_07_00_FF;
   localparam logic [39:0] GPMUX_DRIVE_MASK = 40'h00_00_05_00_00;

   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   localparam logic [7:0] GPMUX_DIR_RST = 8'h00;
   localparam logic [7:0] GPMUX_LATCH_RST = 8'hFF;
   localparam logic [7:0] GPMUX_FUNC_RST = 8'h00;
   localparam logic [7:0] GPMUX_DRIVE_RST = 8'h00;

   // ----------------------------------------------------------------
   // function bit positions
   // ----------------------------------------------------------------
   localparam int GPMUX_N_TXD = 0;
   localparam int GPMUX_N_RXD = 1;
   localparam int GPMUX_N_SCLK = 2;
   localparam int GPMUX_L_T8_0 = 0;
   localparam int GPMUX_L_T8_1 = 1;
   localparam int GPMUX_L_T8_2 = 2;
   localparam int GPMUX_L_T8_3 = 3;
   localparam int GPMUX_L_T16_0A = 4;
   localparam int GPMUX_L_T16_0B = 5;
   localparam int GPMUX_L_T16_1A = 6;
   localparam int GPMUX_L_T16_1B = 7;

endpackage

// file: hdl/gpmux_port.sv
`timescale 1ns/10ps
`default_nettype none
module gpmux_port
   import gpmux_pkg::*;
#(
   parameter logic [7:0] FUNC_MASK = 8'h00,
   parameter logic [7:0] DRIVE_MASK = 8'h00
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic wr_data_en,
   input wire logic wr_dir_en,
   input wire logic wr_func_en,
   input wire logic wr_drive_en,
   input wire logic [7:0] wdata,
   input wire logic [7:0] pin_in,
   input wire logic [7:0] alt_out,
   input wire logic [7:0] alt_oe,
   output logic [7:0] pin_out,
   output logic [7:0] pin_oe,
   output logic [7:0] rd_data,
   output logic [7:0] func_sel
);

   typedef struct packed {
      logic [7:0] latch;
      logic [7:0] dir;
      logic [7:0] func;
      logic [7:0] drive;
      logic [7:0] pout;
      logic [7:0] poe;
   } gpmux_port_st_t;

   gpmux_port_st_t st_ff;
   gpmux_port_st_t nxt_st;
   logic [7:0] drv;
   logic [7:0] val;
   logic [7:0] wdata_q;

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      nxt_st = st_ff;
      if (wr_data_en) begin
         nxt_st.latch = wdata; // RULE14
      end
      if (wr_dir_en) begin
         nxt_st.dir = wdata; // RULE1
      end
      if (wr_func_en) begin
         nxt_st.func = wdata & FUNC_MASK; // RULE8
      end
      if (wr_drive_en) begin
         nxt_st.drive = wdata & DRIVE_MASK; // RULE10
      end
      // function pins follow the peripheral, others the direction bit
      drv = (st_ff.func & alt_oe) | (~st_ff.func & st_ff.dir); // RULE1
      val = (st_ff.func & alt_out) | (~st_ff.func & st_ff.latch);
      nxt_st.pout = val;
      nxt_st.poe = drv & ~(st_ff.drive & val); // RULE10
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_ff <= '{latch: GPMUX_LATCH_RST, dir: GPMUX_DIR_RST, func: GPMUX_FUNC_RST,
            drive: GPMUX_DRIVE_RST, pout: GPMUX_LATCH_RST, poe: GPMUX_DIR_RST}; // RULE2 RULE3
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign pin_out = st_ff.pout;
   assign pin_oe = st_ff.poe;
   assign func_sel = st_ff.func;
   assign rd_data = (st_ff.dir & st_ff.latch) | (~st_ff.dir & pin_in); // RULE14

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   sequence s_dir_write;
      wr_dir_en && !wr_func_en;
   endsequence

   chk_reset_state: assert property (@(posedge pclk) disable iff (!presetn) // RULE2
      $rose(presetn) |-> st_ff.dir == GPMUX_DIR_RST && st_ff.latch == GPMUX_LATCH_RST
      && pin_oe == GPMUX_DIR_RST)
      else $error("port not in input state after reset");

   chk_dir_drive: assert property (@(posedge pclk) disable iff (!presetn) // RULE1
      s_dir_write ##1 (!wr_func_en && st_ff.func == 8'h00 && st_ff.drive == 8'h00)
      |=> pin_oe == $past(st_ff.dir, 1))
      else $error("pin enable does not follow direction bits");

   chk_latch_read: assert property (@(posedge pclk) disable iff (!presetn) // RULE14
      wr_data_en |=> (st_ff.latch == $past(wdata)) && ((rd_data & st_ff.dir) == (wdata_q & st_ff.dir)))
      else $error("latch or readback mismatch");

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wdata_q <= 8'h00;
      end else begin
         wdata_q <= wdata;
      end
   end

   chk_open_drain: assert property (@(posedge pclk) disable iff (!presetn) // RULE10
      (pin_oe & $past(st_ff.drive) & pin_out) == 8'h00 && (st_ff.func & ~FUNC_MASK) == 8'h00)
      else $error("open-drain pin drives high");

endmodule
`default_nettype wire

// file: hdl/gpmux_top.sv
// The APB interface to the registers was left to the implementer.
`timescale 1ns/10ps
`default_nettype none
// Functional notes
// RULE1: each pin direction bit: 0 input, 1 drives output latch
// RULE2: reset clears all direction bits, pins come up as inputs
// RULE3: reset presets every output latch to 1, pins stay inputs
// RULE4: port M pins are plain I/O with no alternate function
// RULE5: port L function bits 3..0 feed 8-bit timer capture inputs three..zero
// RULE6: port L bits 7..4 feed 16-bit timer one b, a, zero b, a
// RULE7: port N pins 0,1,2 carry serial transmit, receive, clock or clear-to-send
// RULE8: port N function bits 2..0 select serial use; bits 7..3 absent
// RULE9: reset clears port N direction and function registers
// RULE10: port N pins 0 and 2 drive type: 0 push-pull, 1 open-drain
// RULE11: ports O and P plain I/O, direction resets to 0
// RULE12: port L pins 0..3 feed 8-bit, 4..7 feed 16-bit timers
// RULE13: reset clears port L direction and function registers
// RULE14: data read gives pin for inputs, latch for outputs; writes hit latch
// RULE15: control registers are write-only; software keeps shadow copies
module gpmux_top
   import gpmux_pkg::*;
#(
   parameter int ADDR_W = 12
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [7:0] pin_l_in,
   output logic [7:0] pin_l_out,
   output logic [7:0] pin_l_oe,
   input wire logic [7:0] pin_m_in,
   output logic [7:0] pin_m_out,
   output logic [7:0] pin_m_oe,
   input wire logic [7:0] pin_n_in,
   output logic [7:0] pin_n_out,
   output logic [7:0] pin_n_oe,
   input wire logic [7:0] pin_o_in,
   output logic [7:0] pin_o_out,
   output logic [7:0] pin_o_oe,
   input wire logic [7:0] pin_p_in,
   output logic [7:0] pin_p_out,
   output logic [7:0] pin_p_oe,
   output logic timer8_zero_input,
   output logic timer8_one_input,
   output logic timer8_two_input,
   output logic timer8_three_input,
   output logic timer16_zero_input_a,
   output logic timer16_zero_input_b,
   output logic timer16_one_input_a,
   output logic timer16_one_input_b,
   input wire logic serial_transmit_data,
   input wire logic serial_clock_out,
   input wire logic serial_clock_oe,
   output logic serial_receive_data,
   output logic serial_clock,
   output logic serial_clear_to_send
);

   typedef struct packed {
      logic [31:0] rdata;
      logic ready;
      logic err;
      logic [3:0] t8;
      logic [3:0] t16;
      logic rxd;
      logic sclk;
      logic cts;
   } gpmux_top_st_t;

   gpmux_top_st_t st_ff;
   gpmux_top_st_t nxt_st;

   logic [GPMUX_IDX_W-1:0] idx;
   logic setup;
   logic wr_go;
   logic [GPMUX_PORTS-1:0] hit_data;
   logic [GPMUX_PORTS-1:0] hit_dir;
   logic [GPMUX_PORTS-1:0] hit_func;
   logic [GPMUX_PORTS-1:0] hit_drive;
   logic [GPMUX_PORTS*8-1:0] pin_in_all;
   logic [GPMUX_PORTS*8-1:0] pin_out_all;
   logic [GPMUX_PORTS*8-1:0] pin_oe_all;
   logic [GPMUX_PORTS*8-1:0] rd_all;
   logic [GPMUX_PORTS*8-1:0] func_all;
   logic [GPMUX_PORTS*8-1:0] alt_out_all;
   logic [GPMUX_PORTS*8-1:0] alt_oe_all;
   logic [7:0] func_l;
   logic [7:0] func_n;

   // ----------------------------------------------------------------
   // address decode
   // ----------------------------------------------------------------
   assign idx = paddr[GPMUX_IDX_LSB +: GPMUX_IDX_W];
   assign setup = psel && !penable;
   assign wr_go = psel && penable && pwrite && st_ff.ready && pstrb[0];

   assign pin_in_all = {pin_p_in, pin_o_in, pin_n_in, pin_m_in, pin_l_in};
   assign func_l = func_all[GPMUX_P_L*8 +: 8];
   assign func_n = func_all[GPMUX_P_N*8 +: 8];

   // serial peripheral drive onto port N pins 0 and 2
   always_comb begin
      alt_out_all = '0;
      alt_oe_all = '0;
      alt_out_all[GPMUX_P_N*8 + GPMUX_N_TXD] = serial_transmit_data; // RULE7
      alt_oe_all[GPMUX_P_N*8 + GPMUX_N_TXD] = 1'b1;
      alt_out_all[GPMUX_P_N*8 + GPMUX_N_SCLK] = serial_clock_out;
      alt_oe_all[GPMUX_P_N*8 + GPMUX_N_SCLK] = serial_clock_oe;
   end

   // ----------------------------------------------------------------
   // port banks
   // ----------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < GPMUX_PORTS; g = g + 1) begin : g_port
         assign hit_data[g] = idx == GPMUX_DATA_IDX[g*8 +: 8];
         assign hit_dir[g] = idx == GPMUX_DIR_IDX[g*8 +: 8];
         assign hit_func[g] = (GPMUX_FUNC_MASK[g*8 +: 8] != 8'h00)
            && idx == GPMUX_FUNC_IDX[g*8 +: 8]; // RULE4 RULE11
         assign hit_drive[g] = (GPMUX_DRIVE_MASK[g*8 +: 8] != 8'h00)
            && idx == GPMUX_DRIVE_IDX[g*8 +: 8];
         gpmux_port #(
            .FUNC_MASK(GPMUX_FUNC_MASK[g*8 +: 8]),
            .DRIVE_MASK(GPMUX_DRIVE_MASK[g*8 +: 8])
         ) u_port (
            .pclk(pclk),
            .presetn(presetn),
            .wr_data_en(wr_go && hit_data[g]),
            .wr_dir_en(wr_go && hit_dir[g]),
            .wr_func_en(wr_go && hit_func[g]),
            .wr_drive_en(wr_go && hit_drive[g]),
            .wdata(pwdata[7:0]),
            .pin_in(pin_in_all[g*8 +: 8]),
            .alt_out(alt_out_all[g*8 +: 8]),
            .alt_oe(alt_oe_all[g*8 +: 8]),
            .pin_out(pin_out_all[g*8 +: 8]),
            .pin_oe(pin_oe_all[g*8 +: 8]),
            .rd_data(rd_all[g*8 +: 8]),
            .func_sel(func_all[g*8 +: 8])
         );
      end
   endgenerate

   // ----------------------------------------------------------------
   // bus answer and peripheral routing
   // ----------------------------------------------------------------
   always_comb begin
      nxt_st = st_ff;
      nxt_st.ready = setup;
      if (setup) begin
         nxt_st.rdata = 32'h0000_0000; // RULE15
         nxt_st.err = ~|{hit_data, hit_dir, hit_func, hit_drive};
         for (int k = 0; k < GPMUX_PORTS; k++) begin
            if (hit_data[k] && !pwrite) begin
               nxt_st.rdata = {24'h000000, rd_all[k*8 +: 8]}; // RULE14
            end
         end
      end else if (!psel) begin
         nxt_st.err = 1'b0;
      end
      nxt_st.t8[0] = func_l[GPMUX_L_T8_0] & pin_l_in[GPMUX_L_T8_0]; // RULE5 RULE12
      nxt_st.t8[1] = func_l[GPMUX_L_T8_1] & pin_l_in[GPMUX_L_T8_1];
      nxt_st.t8[2] = func_l[GPMUX_L_T8_2] & pin_l_in[GPMUX_L_T8_2];
      nxt_st.t8[3] = func_l[GPMUX_L_T8_3] & pin_l_in[GPMUX_L_T8_3];
      nxt_st.t16[0] = func_l[GPMUX_L_T16_0A] & pin_l_in[GPMUX_L_T16_0A]; // RULE6
      nxt_st.t16[1] = func_l[GPMUX_L_T16_0B] & pin_l_in[GPMUX_L_T16_0B];
      nxt_st.t16[2] = func_l[GPMUX_L_T16_1A] & pin_l_in[GPMUX_L_T16_1A];
      nxt_st.t16[3] = func_l[GPMUX_L_T16_1B] & pin_l_in[GPMUX_L_T16_1B];
      nxt_st.rxd = func_n[GPMUX_N_RXD] & pin_n_in[GPMUX_N_RXD]; // RULE7 RULE8
      nxt_st.sclk = func_n[GPMUX_N_SCLK] & pin_n_in[GPMUX_N_SCLK];
      nxt_st.cts = func_n[GPMUX_N_SCLK] & pin_n_in[GPMUX_N_SCLK];
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_ff <= '0; // RULE9 RULE13
      end else begin
         st_ff <= nxt_st;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign prdata = st_ff.rdata;
   assign pready = st_ff.ready;
   assign pslverr = st_ff.err;
   assign pin_l_out = pin_out_all[GPMUX_P_L*8 +: 8];
   assign pin_l_oe = pin_oe_all[GPMUX_P_L*8 +: 8];
   assign pin_m_out = pin_out_all[GPMUX_P_M*8 +: 8];
   assign pin_m_oe = pin_oe_all[GPMUX_P_M*8 +: 8];
   assign pin_n_out = pin_out_all[GPMUX_P_N*8 +: 8];
   assign pin_n_oe = pin_oe_all[GPMUX_P_N*8 +: 8];
   assign pin_o_out = pin_out_all[GPMUX_P_O*8 +: 8];
   assign pin_o_oe = pin_oe_all[GPMUX_P_O*8 +: 8];
   assign pin_p_out = pin_out_all[GPMUX_P_P*8 +: 8];
   assign pin_p_oe = pin_oe_all[GPMUX_P_P*8 +: 8];
   assign timer8_zero_input = st_ff.t8[0];
   assign timer8_one_input = st_ff.t8[1];
   assign timer8_two_input = st_ff.t8[2];
   assign timer8_three_input = st_ff.t8[3];
   assign timer16_zero_input_a = st_ff.t16[0];
   assign timer16_zero_input_b = st_ff.t16[1];
   assign timer16_one_input_a = st_ff.t16[2];
   assign timer16_one_input_b = st_ff.t16[3];
   assign serial_receive_data = st_ff.rxd;
   assign serial_clock = st_ff.sclk;
   assign serial_clear_to_send = st_ff.cts;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   sequence s_setup;
      psel && !penable;
   endsequence

   sequence s_access;
      psel && penable && pready;
   endsequence

   chk_apb_ready: assert property (@(posedge pclk) disable iff (!presetn)
      s_setup |=> s_access ##1 !pready)
      else $error("apb access not answered in one cycle");

   chk_wo_read: assert property (@(posedge pclk) disable iff (!presetn) // RULE15
      s_setup ##0 (!pwrite && (|hit_dir || |hit_func || |hit_drive)) |=> prdata == 32'h0)
      else $error("write-only register reads nonzero");

   chk_unmapped_err: assert property (@(posedge pclk) disable iff (!presetn)
      s_setup ##0 !(|{hit_data, hit_dir, hit_func, hit_drive}) |=> pslverr && pready)
      else $error("unmapped access without error");

   chk_port_m_plain: assert property (@(posedge pclk) disable iff (!presetn) // RULE4
      func_all[GPMUX_P_M*8 +: 8] == 8'h00 && func_all[GPMUX_P_O*8 +: 8] == 8'h00
      && func_all[GPMUX_P_P*8 +: 8] == 8'h00)
      else $error("plain port gained a function");

   chk_timer8_route: assert property (@(posedge pclk) disable iff (!presetn) // RULE5
      !func_l[GPMUX_L_T8_3] |=> !timer8_three_input)
      else $error("timer input fed from port pin");

   chk_timer16_route: assert property (@(posedge pclk) disable iff (!presetn) // RULE6
      (func_l[GPMUX_L_T16_1B] && pin_l_in[GPMUX_L_T16_1B]) |=> timer16_one_input_b)
      else $error("16-bit timer input not routed");

   chk_serial_tx: assert property (@(posedge pclk) disable iff (!presetn) // RULE7
      (func_n[GPMUX_N_TXD] && !pin_n_oe[GPMUX_N_TXD] == 1'b0) [*2]
      |-> pin_n_out[GPMUX_N_TXD] == $past(serial_transmit_data))
      else $error("transmit pin does not follow serial data");

   chk_func_width: assert property (@(posedge pclk) disable iff (!presetn) // RULE8
      func_n[7:3] == 5'h00)
      else $error("unimplemented function bits set");

   sequence s_mapped;
      |{hit_data, hit_dir, hit_func, hit_drive};
   endsequence

   chk_mapped_ok: assert property (@(posedge pclk) disable iff (!presetn)
      s_setup ##0 s_mapped |=> !pslverr && pready)
      else $error("mapped access flagged as error");

   chk_read_upper: assert property (@(posedge pclk) disable iff (!presetn) // RULE14
      s_access |-> prdata[31:8] == 24'h000000)
      else $error("read data upper bits not zero");

   chk_rx_route: assert property (@(posedge pclk) disable iff (!presetn) // RULE7
      (func_n[GPMUX_N_RXD] && pin_n_in[GPMUX_N_RXD]) |=> serial_receive_data)
      else $error("receive pin not routed to serial");

   chk_rx_block: assert property (@(posedge pclk) disable iff (!presetn) // RULE8
      !func_n[GPMUX_N_RXD] |=> !serial_receive_data)
      else $error("receive input fed while pin is a port");

   chk_clock_route: assert property (@(posedge pclk) disable iff (!presetn) // RULE7
      (func_n[GPMUX_N_SCLK] && pin_n_in[GPMUX_N_SCLK]) |=> serial_clock && serial_clear_to_send)
      else $error("clock pin not routed to serial");

   chk_timer8_zero: assert property (@(posedge pclk) disable iff (!presetn) // RULE5
      (func_l[GPMUX_L_T8_0] && pin_l_in[GPMUX_L_T8_0]) |=> timer8_zero_input)
      else $error("8-bit timer zero input not routed");

   chk_timer16_zero: assert property (@(posedge pclk) disable iff (!presetn) // RULE6
      !func_l[GPMUX_L_T16_0A] |=> !timer16_zero_input_a)
      else $error("16-bit timer input fed from port pin");

   chk_l_reset: assert property (@(posedge pclk) disable iff (!presetn) // RULE13
      $rose(presetn) |-> func_l == 8'h00 && pin_l_oe == 8'h00)
      else $error("port L not an input port after reset");

   chk_n_reset: assert property (@(posedge pclk) disable iff (!presetn) // RULE9
      $rose(presetn) |-> func_n == 8'h00 && pin_n_oe == 8'h00)
      else $error("port N not an input port after reset");

endmodule
`default_nettype wire

// file: verification/gpio_ports_l_to_p_mux_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module gpio_ports_l_to_p_mux_tb_top
   import gpmux_pkg::*;
;
   logic pclk;
   logic presetn;
   logic psel, penable, pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata;
   logic [3:0] pstrb;
   logic [31:0] prdata;
   logic pready, pslverr;
   wire [7:0] po [GPMUX_PORTS];
   wire [7:0] poe [GPMUX_PORTS];
   wire [7:0] pin [GPMUX_PORTS];
   logic [7:0] ev [GPMUX_PORTS];
   logic [7:0] een [GPMUX_PORTS];
   wire [7:0] tmr;
   wire [2:0] ser;
   logic stx, sck_out, sck_oe;
   int errors = 0;
   int check_count = 0;

   gpmux_top dut_u (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .pin_l_in(pin[0]), .pin_l_out(po[0]), .pin_l_oe(poe[0]),
      .pin_m_in(pin[1]), .pin_m_out(po[1]), .pin_m_oe(poe[1]),
      .pin_n_in(pin[2]), .pin_n_out(po[2]), .pin_n_oe(poe[2]),
      .pin_o_in(pin[3]), .pin_o_out(po[3]), .pin_o_oe(poe[3]),
      .pin_p_in(pin[4]), .pin_p_out(po[4]), .pin_p_oe(poe[4]),
      .timer8_zero_input(tmr[0]), .timer8_one_input(tmr[1]),
      .timer8_two_input(tmr[2]), .timer8_three_input(tmr[3]),
      .timer16_zero_input_a(tmr[4]), .timer16_zero_input_b(tmr[5]),
      .timer16_one_input_a(tmr[6]), .timer16_one_input_b(tmr[7]),
      .serial_transmit_data(stx), .serial_clock_out(sck_out),
      .serial_clock_oe(sck_oe), .serial_receive_data(ser[0]),
      .serial_clock(ser[1]), .serial_clear_to_send(ser[2])
   );

   for (genvar k = 0; k < GPMUX_PORTS; k++) begin : g_pin
      gpmux_pin_model pm_u (
         .pclk(pclk), .ext_val(ev[k]), .ext_en(een[k]),
         .pin_out(po[k]), .pin_oe(poe[k]), .pin_in(pin[k])
      );
   end

   initial begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end

   // ---------------------------------
   // checking and bus tasks
   // ---------------------------------
   task automatic conclude();
      $display("checks=%0d errors=%0d", check_count, errors);
      if (errors == 0 && check_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp) begin
         errors++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic xfer(input logic [7:0] idx, input logic wr_en, input logic [7:0] d,
      input logic [3:0] st, output logic [7:0] q, output logic err);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr_en;
      paddr <= {2'b00, idx, 2'b00};
      pwdata <= {24'h000000, d};
      pstrb <= st;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      q = prdata[7:0];
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      logic [7:0] q;
      logic e;
      xfer(idx, 1'b1, d, 4'hF, q, e);
   endtask

   task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp, input logic exp_err);
      logic [7:0] q;
      logic e;
      xfer(idx, 1'b0, 8'h00, 4'hF, q, e);
      check(q, exp);
      check({7'h00, e}, {7'h00, exp_err});
   endtask

   task automatic settle();
      repeat (4) @(posedge pclk);
   endtask

   task automatic reset_chk();
      for (int k = 0; k < GPMUX_PORTS; k++) begin
         check(poe[k], 8'h00);
         check(po[k], 8'hFF);
         rd_chk(GPMUX_DATA_IDX[8*k+:8], ev[k], 1'b0);
      end
      check(tmr, 8'h00);
      check({5'h00, ser}, 8'h00);
   endtask

   initial begin
      repeat (5000) @(posedge pclk);
      errors++;
      conclude();
   end

   // ---------------------------------
   // test sequence
   // ---------------------------------
   initial begin
      logic [7:0] q;
      logic e;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h00000000;
      pstrb = 4'hF;
      stx = 1'b0;
      sck_out = 1'b0;
      sck_oe = 1'b0;
      presetn = 1'b0;
      for (int k = 0; k < GPMUX_PORTS; k++) begin
         ev[k] = 8'h00;
         een[k] = 8'hFF;
      end
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      reset_chk();
      rd_chk(8'hC2, 8'h00, 1'b1);
      rd_chk(GPMUX_IDX_L_DIR[7:0], 8'h00, 1'b0);
      $display("test reset done");
      for (int k = 0; k < GPMUX_PORTS; k++) begin
         ev[k] <= 8'h3C;
         wr(GPMUX_DATA_IDX[8*k+:8], 8'hA5);
         settle();
         check(poe[k], 8'h00);
         rd_chk(GPMUX_DATA_IDX[8*k+:8], 8'h3C, 1'b0);
         wr(GPMUX_DIR_IDX[8*k+:8], 8'h0F);
         settle();
         check(poe[k], 8'h0F);
         check(po[k] & 8'h0F, 8'h05);
         rd_chk(GPMUX_DATA_IDX[8*k+:8], 8'h35, 1'b0);
         xfer(GPMUX_DATA_IDX[8*k+:8], 1'b1, 8'h00, 4'hE, q, e);
         settle();
         check(po[k] & 8'h0F, 8'h05);
         wr(GPMUX_DIR_IDX[8*k+:8], 8'h00);
      end
      $display("test ports done");
      for (int i = 0; i < 4; i++) begin
         q = (i == 2) ? 8'h0F : (i == 3) ? 8'h81 : 8'hFF;
         ev[0] <= (i % 2 == 0) ? 8'h5A : 8'hA5;
         wr(GPMUX_IDX_L_FUNC[7:0], q);
         settle();
         check(tmr, q & ev[0]);
         check(poe[0], 8'h00);
      end
      $display("test timers done");
      ev[2] <= 8'hA2;
      sck_out <= 1'b1;
      sck_oe <= 1'b1;
      wr(GPMUX_IDX_N_DIR[7:0], 8'hF8);
      wr(GPMUX_IDX_N_FUNC[7:0], 8'hFF);
      settle();
      check(poe[2], 8'hFD);
      check(po[2] & 8'h05, 8'h04);
      check({5'h00, ser}, 8'h07);
      stx <= 1'b1;
      sck_oe <= 1'b0;
      settle();
      check(poe[2], 8'hF9);
      check({5'h00, ser}, 8'h01);
      wr(GPMUX_IDX_N_DRIVE[7:0], 8'hFF);
      sck_out <= 1'b0;
      sck_oe <= 1'b1;
      settle();
      check(poe[2], 8'hFC);
      stx <= 1'b0;
      sck_out <= 1'b1;
      settle();
      check(poe[2], 8'hF9);
      $display("test serial done");
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      reset_chk();
      $display("test second reset done");
      conclude();
   end
endmodule
`default_nettype wire

// file: verification/gpmux_pin_model.sv
`timescale 1ns/10ps
`default_nettype none
module gpmux_pin_model (
   input wire logic pclk,
   input wire logic [7:0] ext_val,
   input wire logic [7:0] ext_en,
   input wire logic [7:0] pin_out,
   input wire logic [7:0] pin_oe,
   output logic [7:0] pin_in
);
   // ---------------------------------
   // wire level of one port
   // ---------------------------------
   logic flt_ff;
   initial flt_ff = 1'b0;
   // undriven pins wander, no stale level
   always @(posedge pclk) begin
      flt_ff <= ~flt_ff;
   end
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         pin_in[i] = pin_oe[i] ? pin_out[i] : (ext_en[i] ? ext_val[i] : flt_ff);
      end
   end
endmodule
`default_nettype wire
